// ---- hw/pmcd_pkg.sv ----
package pmcd_pkg;
  // Register bus
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 32;
  localparam logic [3:0]  REG_VR         = 4'h0;
  localparam logic [3:0]  REG_PLL        = 4'h1;
  localparam logic [3:0]  REG_DIV        = 4'h2;
  localparam logic [3:0]  REG_STAT       = 4'h3;

  // regulator_control_reg fields
  localparam int          VR_LEVEL_LSB   = 0;
  localparam int          VR_VCODE_LSB   = 4;
  localparam int          VR_BYPASS_BIT  = 8;
  localparam logic [1:0]  VR_LEVEL_RST   = 2'h3;
  localparam logic [1:0]  VR_LEVEL_OFF   = 2'h0;
  localparam logic [3:0]  VR_VCODE_RST   = 4'h6;

  // pll_control_reg fields
  localparam int          PLL_MULT_LSB   = 0;
  localparam int          PLL_OFF_BIT    = 6;
  localparam int          PLL_BYPASS_BIT = 8;
  localparam int          PLL_SLEEP_BIT  = 9;
  localparam int          PLL_DEEP_BIT   = 10;
  localparam logic [5:0]  PLL_MULT_RST   = 6'h0a;
  localparam logic [5:0]  PLL_MULT_MIN   = 6'h01;

  // Divider register fields
  localparam int          DIV_SYS_LSB    = 0;
  localparam int          DIV_CORE_LSB   = 4;
  localparam logic [3:0]  DIV_SYS_RST    = 4'h5;
  localparam logic [1:0]  DIV_CORE_RST   = 2'h0;
  localparam logic [3:0]  DIV_ONE        = 4'h1;

  // Core voltage target
  localparam logic [11:0] VCORE_BASE_MV  = 12'h2bc;
  localparam logic [11:0] VCORE_STEP_MV  = 12'h032;

  // Status register fields
  localparam int          STAT_MODE_LSB  = 0;
  localparam int          STAT_MULT_LSB  = 4;
  localparam int          STAT_VMV_LSB   = 12;

  typedef enum {PMCD_FULL_ON, PMCD_ACTIVE, PMCD_SLEEP, PMCD_DEEP, PMCD_HIBER} pmcd_mode_t;

  function automatic logic [3:0] pmcd_core_ratio(input logic [1:0] sel);
    pmcd_core_ratio = 4'h1 << sel;
  endfunction : pmcd_core_ratio

  function automatic logic [11:0] pmcd_vcore_mv(input logic [3:0] code);
    pmcd_vcore_mv = VCORE_BASE_MV + 12'(code * VCORE_STEP_MV);
  endfunction : pmcd_vcore_mv
endpackage : pmcd_pkg

// ---- hw/pmcd_sync.sv ----
`timescale 1ns/1ns
module pmcd_sync (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Asynchronous levels in, synchronised out
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] stage1;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1   <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pmcd_sync

// ---- hw/pmcd_clk_div.sv ----
`timescale 1ns/1ns
module pmcd_clk_div (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Control
  input  wire logic [3:0] ratio,
  input  wire logic       run,
  // One enable pulse per output period
  output logic            tick
);
  logic [3:0] count;

  // New ratio only sampled at the wrap, so a period is never cut short
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= 4'h0;
      tick  <= 1'b0;
    end else if (count == 4'h0) begin
      count <= (ratio > 4'h1) ? ratio - 4'h1 : 4'h0;
      tick  <= run;
    end else begin
      count <= count - 4'h1;
      tick  <= 1'b0;
    end
  end
endmodule : pmcd_clk_div

// ---- hw/pmcd_ctrl.sv ----
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ns
module pmcd_ctrl (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [pmcd_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pmcd_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [pmcd_pkg::DATA_W-1:0] reg_rdata,
  // Wake sources, asynchronous
  input  wire logic                       wake_pin,
  input  wire logic                       rtc_wake,
  // DMA and asynchronous peripheral gating
  input  wire logic                       dma_l1_req,
  output logic                            dma_l1_grant,
  output logic                            async_access_en,
  // Clock enables
  output logic                            core_clock,
  output logic                            sys_clock,
  // PLL control
  output logic                            pll_enable,
  output logic                            pll_bypass,
  output logic      [5:0]                 pll_mult,
  // Regulator control
  output logic                            vreg_enable,
  output logic                            vreg_bypass,
  output logic      [11:0]                vcore_target_mv,
  // Pins and boot
  output logic                            pins_hiz,
  output logic                            boot_start
);
  import pmcd_pkg::*;

  pmcd_mode_t  mode;
  pmcd_mode_t  next_mode;
  logic [1:0]  level;
  logic [3:0]  vcode;
  logic        vr_byp;
  logic [5:0]  mult_req;
  logic        pll_off;
  logic        byp_bit;
  logic [3:0]  sys_sel;
  logic [1:0]  core_sel;
  logic [1:0]  wake_sync;
  logic [1:0]  wake_prev;
  logic        wake_rise;
  logic        rtc_rise;
  logic        wr_vr;
  logic        wr_pll;
  logic        wr_div;
  logic        running;
  logic        core_run;
  logic        sys_run;
  logic [3:0]  core_ratio;
  logic [3:0]  sys_ratio;
  logic [5:0]  w_mult;
  logic        mult_ok;
  logic        req_hiber;
  logic        req_deep;
  logic        req_sleep;
  logic        hib_exit;
  logic [31:0] next_rdata;

  // Shared write decode; all operands come in as arguments so assigns track them
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] idx);
    wr_hit = wr && (addr == idx);
  endfunction : wr_hit

  pmcd_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({rtc_wake, wake_pin}),
    .sync_out (wake_sync)
  );

  // Edge flops reset to the idle low level, so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_prev <= 2'h0;
    end else begin
      wake_prev <= wake_sync;
    end
  end

  assign wake_rise = wake_sync[0] & ~wake_prev[0];
  assign rtc_rise  = wake_sync[1] & ~wake_prev[1];

  // Software runs only while the core clock does
  assign running = (mode == PMCD_FULL_ON) || (mode == PMCD_ACTIVE);
  assign wr_vr   = wr_hit(reg_wr && running, reg_addr, REG_VR);
  assign wr_pll  = wr_hit(reg_wr && running, reg_addr, REG_PLL);
  assign wr_div  = wr_hit(reg_wr && running, reg_addr, REG_DIV);
  assign w_mult  = reg_wdata[PLL_MULT_LSB +: 6];
  assign mult_ok = (w_mult >= PLL_MULT_MIN);

  // Requests act on the write itself; the sleep and deep bits are never stored, the Off level is
  assign req_hiber = wr_vr && (reg_wdata[VR_LEVEL_LSB +: 2] == VR_LEVEL_OFF);
  assign req_deep  = wr_pll && reg_wdata[PLL_DEEP_BIT];
  assign req_sleep = wr_pll && reg_wdata[PLL_SLEEP_BIT];
  assign hib_exit  = (mode == PMCD_HIBER) && (next_mode != PMCD_HIBER);

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      PMCD_FULL_ON, PMCD_ACTIVE: begin
        if (req_hiber) begin
          next_mode = PMCD_HIBER;
        end else if (req_deep) begin
          next_mode = PMCD_DEEP;
        end else if (req_sleep) begin
          next_mode = PMCD_SLEEP;
        end else if (wr_pll) begin
          next_mode = reg_wdata[PLL_BYPASS_BIT] ? PMCD_ACTIVE : PMCD_FULL_ON;
        end
      end
      PMCD_SLEEP: begin
        if (wake_rise || rtc_rise) begin
          next_mode = byp_bit ? PMCD_ACTIVE : PMCD_FULL_ON;
        end
      end
      PMCD_DEEP: begin
        // Only the RTC may wake it; rst_n covers the reset path
        if (rtc_rise) begin
          next_mode = PMCD_ACTIVE;
        end
      end
      PMCD_HIBER: begin
        // The reset pin wake path is the synchronous reset itself
        if (rtc_rise) begin
          next_mode = PMCD_FULL_ON;
        end
      end
      default: next_mode = PMCD_FULL_ON;
    endcase
  end

  // Reset returns any mode to Full-On, which also covers the reset wake
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode <= PMCD_FULL_ON;
    end else begin
      mode <= next_mode;
    end
  end

  // Boot pulse on leaving hibernation
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_start <= 1'b0;
    end else begin
      boot_start <= hib_exit;
    end
  end

  // Regulator control register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      level  <= VR_LEVEL_RST;
      vcode  <= VR_VCODE_RST;
      vr_byp <= 1'b0;
    end else if (hib_exit) begin
      level  <= VR_LEVEL_RST;
      vcode  <= VR_VCODE_RST;
      vr_byp <= 1'b0;
    end else if (wr_vr) begin
      level  <= reg_wdata[VR_LEVEL_LSB +: 2];
      vcode  <= reg_wdata[VR_VCODE_LSB +: 4];
      vr_byp <= reg_wdata[VR_BYPASS_BIT];
    end
  end

  // PLL control register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mult_req <= PLL_MULT_RST;
      pll_off  <= 1'b0;
      byp_bit  <= 1'b0;
    end else if (mode == PMCD_DEEP && next_mode == PMCD_ACTIVE) begin
      // Deep Sleep wakes into Active, so the stored bypass must agree
      byp_bit  <= 1'b1;
    end else if (hib_exit) begin
      mult_req <= PLL_MULT_RST;
      pll_off  <= 1'b0;
      byp_bit  <= 1'b0;
    end else if (wr_pll) begin
      // A zero multiplier is not a legal setting and is dropped
      if (mult_ok) begin
        mult_req <= w_mult;
      end
      pll_off <= reg_wdata[PLL_OFF_BIT];
      byp_bit <= reg_wdata[PLL_BYPASS_BIT];
    end
  end

  // Applied multiplier: held while bypassed, loaded on Full-On
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_mult <= PLL_MULT_RST;
    end else if (next_mode == PMCD_FULL_ON) begin
      // A write that leaves Active carries its own multiplier straight in
      pll_mult <= (wr_pll && mult_ok) ? w_mult : mult_req;
    end
  end

  // Divider register, zero system divide ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_sel  <= DIV_SYS_RST;
      core_sel <= DIV_CORE_RST;
    end else if (wr_div) begin
      if (reg_wdata[DIV_SYS_LSB +: 4] != 4'h0) begin
        sys_sel <= reg_wdata[DIV_SYS_LSB +: 4];
      end
      core_sel <= reg_wdata[DIV_CORE_LSB +: 2];
    end
  end

  // Bypassed PLL passes the input clock straight through
  assign core_ratio = (mode == PMCD_ACTIVE) ? DIV_ONE : pmcd_core_ratio(core_sel);
  assign sys_ratio  = (mode == PMCD_ACTIVE) ? DIV_ONE : sys_sel;
  assign core_run   = running;
  assign sys_run    = running || (mode == PMCD_SLEEP);

  // Each divider reloads only at its wrap, so no period is ever cut short
  pmcd_clk_div u_core_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ratio   (core_ratio),
    .run     (core_run),
    .tick    (core_clock)
  );

  pmcd_clk_div u_sys_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ratio   (sys_ratio),
    .run     (sys_run),
    .tick    (sys_clock)
  );

  // PLL follows the mode; software may stop it only while in Active
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_enable <= 1'b1;
      pll_bypass <= 1'b0;
    end else begin
      pll_enable <= (mode == PMCD_FULL_ON) || (mode == PMCD_SLEEP) ||
                    (mode == PMCD_ACTIVE && !pll_off);
      pll_bypass <= (mode == PMCD_ACTIVE);
    end
  end

  // Regulator outputs; a bypassed regulator is simply left off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vreg_enable     <= 1'b1;
      vreg_bypass     <= 1'b0;
      vcore_target_mv <= pmcd_vcore_mv(VR_VCODE_RST);
    end else begin
      vreg_enable     <= (mode != PMCD_HIBER) && !vr_byp;
      vreg_bypass     <= vr_byp;
      vcore_target_mv <= (mode == PMCD_HIBER) ? 12'h000 : pmcd_vcore_mv(vcode);
    end
  end

  // Pins and access gating
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pins_hiz        <= 1'b0;
      async_access_en <= 1'b1;
    end else begin
      pins_hiz        <= (mode == PMCD_HIBER);
      async_access_en <= (mode != PMCD_DEEP) && (mode != PMCD_HIBER);
    end
  end

  // Grant lags the request a cycle and stays high at most one cycle past Full-On or Active
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_l1_grant <= 1'b0;
    end else begin
      dma_l1_grant <= dma_l1_req && running;
    end
  end

  // Read word built from the live registers, captured by the strobe below
  always_comb begin
    next_rdata = '0;
    if (reg_addr == REG_VR) begin
      next_rdata[VR_LEVEL_LSB +: 2] = level;
      next_rdata[VR_VCODE_LSB +: 4] = vcode;
      next_rdata[VR_BYPASS_BIT]     = vr_byp;
    end else if (reg_addr == REG_PLL) begin
      next_rdata[PLL_MULT_LSB +: 6] = mult_req;
      next_rdata[PLL_OFF_BIT]       = pll_off;
      next_rdata[PLL_BYPASS_BIT]    = byp_bit;
    end else if (reg_addr == REG_DIV) begin
      next_rdata[DIV_SYS_LSB +: 4]  = sys_sel;
      next_rdata[DIV_CORE_LSB +: 2] = core_sel;
    end else if (reg_addr == REG_STAT) begin
      next_rdata[STAT_MODE_LSB +: 3] = 3'(mode);
      next_rdata[STAT_MULT_LSB +: 6] = pll_mult;
      next_rdata[STAT_VMV_LSB +: 12] = vcore_target_mv;
    end
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : pmcd_ctrl

// ---- verif/pmcd_ctrl_properties.sv ----
`timescale 1ns/1ns
module pmcd_ctrl_properties
  import pmcd_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Watched ports
  input wire logic        dma_l1_req,
  input wire logic        dma_l1_grant,
  input wire logic        async_access_en,
  input wire logic        core_clock,
  input wire logic        sys_clock,
  input wire logic        pll_enable,
  input wire logic        pll_bypass,
  input wire logic [5:0]  pll_mult,
  input wire logic        vreg_enable,
  input wire logic [11:0] vcore_target_mv,
  input wire logic        pins_hiz,
  input wire logic        boot_start
);
  logic [4:0] byp_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Old divide periods may still run out after bypass starts
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !pll_bypass) byp_cnt <= 5'h00;
    else if (byp_cnt != 5'h1f) byp_cnt <= byp_cnt + 5'h01;
  end
  sequence s_hib_exit;
    pins_hiz ##1 !pins_hiz;
  endsequence
  a_hiber_off: assert property (
    pins_hiz |-> !vreg_enable && vcore_target_mv == 12'h000 && !core_clock && !sys_clock)
    else $error("hibernate left power or clocks on");
  a_vcore_step: assert property (
    vcore_target_mv == 12'h000 || (vcore_target_mv - VCORE_BASE_MV) % VCORE_STEP_MV == 0)
    else $error("core voltage off the step grid");
  a_deep_stop: assert property (!async_access_en |-> !core_clock && !sys_clock)
    else $error("clock running while access denied");
  a_bypass_fast: assert property (byp_cnt == 5'h1f && pll_bypass |-> core_clock && sys_clock)
    else $error("bypassed clocks not at input rate");
  a_grant_src: assert property (
    dma_l1_grant |-> $past(dma_l1_req) && async_access_en && !pins_hiz)
    else $error("grant without request or in low power");
  a_reset_vals: assert property (
    $rose(rst_n) |-> pll_mult == PLL_MULT_RST && pll_enable && !pll_bypass)
    else $error("wrong state after reset");
  a_mult_legal: assert property (pll_mult != 6'h00)
    else $error("multiplier zero");
  a_boot_exit: assert property (s_hib_exit |-> $past(boot_start) && !boot_start)
    else $error("no single boot pulse on wake");
  a_boot_cause: assert property (boot_start |-> $past(pins_hiz))
    else $error("boot pulse outside hibernate exit");
endmodule : pmcd_ctrl_properties
bind pmcd_ctrl pmcd_ctrl_properties u_props (.*);

// ---- verif/pmcd_wake_src.sv ----
`timescale 1ns/1ns
module pmcd_wake_src (
  // Commands from the bench
  input  wire logic fire_rtc,
  input  wire logic fire_pin,
  // Wake levels
  output logic      rtc_wake,
  output logic      wake_pin
);
  initial begin
    rtc_wake = 1'b0;
    wake_pin = 1'b0;
  end
  // Off-grid edges, the wake path is asynchronous
  always @(posedge fire_rtc) begin
    #17 rtc_wake = 1'b1;
    #310 rtc_wake = 1'b0;
  end
  always @(posedge fire_pin) begin
    #17 wake_pin = 1'b1;
    #310 wake_pin = 1'b0;
  end
endmodule : pmcd_wake_src

// ---- verif/pmcd_ctrl_bench.sv ----
`timescale 1ns/1ns
module pmcd_ctrl_bench;
  import pmcd_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        wake_pin, rtc_wake, fire_rtc = 1'b0, fire_pin = 1'b0, dma_l1_req = 1'b0;
  logic        dma_l1_grant, async_access_en, core_clock, sys_clock, pll_enable, pll_bypass;
  logic        vreg_enable, vreg_bypass, pins_hiz, boot_start;
  logic [5:0]  pll_mult, mu;
  logic [11:0] vcore_target_mv;
  logic [3:0]  s, v;
  int          mismatches = 0, total_checks = 0, nc, ns, ng, nb, i;
  pmcd_ctrl dut (.*);
  pmcd_wake_src wake (.*);
  always #25 clk_sys = ~clk_sys;
  function automatic logic [31:0] pll(input logic [2:0] f, input logic [5:0] m);
    pll = {21'h0, f, 2'h0, m};
  endfunction : pll
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic md(input logic [2:0] m);
    rd(REG_STAT);
    chk(32'(d[2:0]), 32'(m));
  endtask : md
  task automatic run(input int k);
    nc = 0;
    ns = 0;
    ng = 0;
    nb = 0;
    repeat (k) begin
      @(posedge clk_sys);
      dma_l1_req <= 1'($urandom);
      nc += int'(core_clock === 1'b1);
      ns += int'(sys_clock === 1'b1);
      ng += int'(dma_l1_grant === 1'b1);
      nb += int'(boot_start === 1'b1);
    end
  endtask : run
  // Second gap only: the first may still carry the old ratio
  task automatic per(input bit c, input logic [31:0] e);
    int n, k;
    repeat (2) begin
      for (k = 0; k < 40 && (c ? core_clock : sys_clock) !== 1'b1; k++) @(posedge clk_sys);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (n < 40 && (c ? core_clock : sys_clock) !== 1'b1);
    end
    chk(32'(n), e);
  endtask : per
  task automatic fire(input bit r);
    if (r) fire_rtc <= 1'b1;
    else fire_pin <= 1'b1;
    @(posedge clk_sys);
    fire_rtc <= 1'b0;
    fire_pin <= 1'b0;
    run(12);
  endtask : fire
  task automatic rst();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : rst
  task print_verdict;
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(83057));
    rst();
    rd(REG_VR);
    chk(d, 32'h63);
    rd(REG_PLL);
    chk(d, 32'h0a);
    rd(REG_DIV);
    chk(d, 32'h05);
    rd(REG_STAT);
    chk(d, 32'h003e80a0);
    rd(4'($urandom_range(15, 4)));
    chk(d, 32'h0);
    for (i = 0; i < 6; i++) begin
      s = i == 0 ? 4'h1 : i == 1 ? 4'hf : 4'($urandom_range(15, 1));
      wr(REG_DIV, {26'h0, i[1:0], s});
      per(1'b0, 32'(s));
      per(1'b1, 32'h1 << i[1:0]);
    end
    wr(REG_DIV, 32'h0);
    per(1'b0, 32'(s));
    wr(REG_PLL, pll(3'h0, 6'h3f));
    chk(32'(pll_mult), 32'h3f);
    mu = 6'($urandom_range(62, 1));
    wr(REG_PLL, pll(3'h0, mu));
    wr(REG_PLL, pll(3'h0, 6'h00));
    chk(32'(pll_mult), 32'(mu));
    for (i = 0; i < 3; i++) begin
      v = i == 0 ? 4'hf : 4'($urandom);
      wr(REG_VR, {24'h0, v, 4'h3});
      chk(32'(vcore_target_mv), 32'h2bc + 32'h32 * 32'(v));
    end
    wr(REG_VR, 32'h163);
    chk(32'({vreg_bypass, vreg_enable}), 32'h2);
    wr(REG_VR, 32'h63);
    wr(REG_PLL, pll(3'h1, mu));
    wr(REG_PLL, pll(3'h1, 6'h3f));
    chk(32'({pll_enable, pll_bypass, pll_mult}), 32'({2'h3, mu}));
    run(40);
    chk(32'(ng > 0), 32'h1);
    per(1'b0, 32'h1);
    per(1'b1, 32'h1);
    wr(REG_PLL, 32'h140 | 32'(mu));
    chk(32'({pll_enable, pll_bypass}), 32'h1);
    wr(REG_PLL, pll(3'h3, 6'h3f));
    md(3'h2);
    run(20);
    chk(32'({nc == 0, ns > 0, ng == 0}), 32'h7);
    fire(1'b1);
    md(3'h1);
    wr(REG_PLL, pll(3'h2, 6'h3f));
    fire(1'b0);
    md(3'h0);
    chk(32'(pll_mult), 32'h3f);
    wr(REG_PLL, pll(3'h4, 6'h3f));
    run(20);
    chk(32'({nc + ns == 0, async_access_en}), 32'h2);
    fire(1'b0);
    md(3'h3);
    fire(1'b1);
    md(3'h1);
    wr(REG_PLL, pll(3'h4, 6'h3f));
    rst();
    md(3'h0);
    chk(32'(pll_mult), 32'h0a);
    wr(REG_VR, 32'h60);
    run(20);
    chk(32'({pins_hiz, vreg_enable, vcore_target_mv, nc + ns == 0}), 32'h4001);
    fire(1'b1);
    chk(32'({nb == 1, pins_hiz}), 32'h2);
    md(3'h0);
    print_verdict();
  end
endmodule : pmcd_ctrl_bench
